// >>> logic/jtbs_pkg.sv
// Constants shared by the boundary-scan test port and its scan chain.
// Assumes nothing beyond a SystemVerilog compiler.
package jtbs_pkg;

  // ----------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------
  localparam int unsigned IR_LEN     = 5;
  localparam logic [4:0]  OP_EXTEST  = 5'h00;
  localparam logic [4:0]  OP_SAMPLE  = 5'h01;
  localparam logic [4:0]  OP_CLAMP   = 5'h04;
  localparam logic [4:0]  OP_HIGHZ   = 5'h05;
  localparam logic [4:0]  OP_IDCODE  = 5'h0c;
  localparam logic [4:0]  OP_BYPASS  = 5'h1f;
  localparam logic [4:0]  IR_CAPTURE = 5'h01;

  // ----------------------------------------------------------------
  // Identification word layout
  // ----------------------------------------------------------------
  localparam int unsigned ID_LEN     = 32;
  localparam int unsigned ID_VER_LSB = 28;
  localparam int unsigned ID_PRT_LSB = 12;
  localparam int unsigned ID_MFR_LSB = 1;
  localparam logic        ID_FIXED   = 1'b1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic        BYP_CAPTURE = 1'b0;
  localparam logic        OE_B_OFF    = 1'b1;

  // ----------------------------------------------------------------
  // Controller states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE,
    ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } jtbs_state_t;

endpackage

// >>> logic/jtbs_bsr_chain.sv
// Boundary scan register: capture stage, serial shift stage, update stage.
// Runs on the test clock; the parallel inputs come from other clock domains.
`timescale 1ns/100ps
`default_nettype none
module jtbs_bsr_chain #(
  parameter int unsigned LEN = 8
) (
  input  wire logic           tck_i,
  input  wire logic           tap_rst_b_i,
  input  wire logic           capture_i,
  input  wire logic           shift_i,
  input  wire logic           update_i,
  input  wire logic           tdi_i,
  input  wire logic [LEN-1:0] par_i,
  output logic                tdo_o,
  output logic      [LEN-1:0] upd_o
);
  import jtbs_pkg::*;

  logic [LEN-1:0] par_meta_reg;
  logic [LEN-1:0] par_sync_reg;
  logic [LEN-1:0] sr_reg;
  logic [LEN-1:0] upd_reg;

  // ----------------------------------------------------------------
  // Pin states are asynchronous to the test clock, so two stages first.
  // ----------------------------------------------------------------
  always_ff @(posedge tck_i or negedge tap_rst_b_i) begin
    if (!tap_rst_b_i) begin
      par_meta_reg <= '0;
      par_sync_reg <= '0;
    end else begin
      par_meta_reg <= par_i;
      par_sync_reg <= par_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // One cell per covered pin, shifting from the input end to the output.
  // ----------------------------------------------------------------
  always_ff @(posedge tck_i or negedge tap_rst_b_i) begin
    if (!tap_rst_b_i) begin
      sr_reg  <= '0;
      upd_reg <= '0;
    end else begin
      if (capture_i) begin
        sr_reg <= par_sync_reg; // [RL17]
      end else if (shift_i) begin
        sr_reg <= {tdi_i, sr_reg[LEN-1:1]}; // [RL13]
      end
      if (update_i) begin
        upd_reg <= sr_reg;
      end
    end
  end

  assign tdo_o = sr_reg[0];
  assign upd_o = upd_reg;

endmodule
`default_nettype wire

// >>> logic/jtbs_tap.sv
// Boundary-scan test access port: controller, instruction and data registers,
// and the pin multiplexing that the instructions steer.
// Assumes the test clock is unrelated to sys_clk_i and the pads sit outside.
//
// Summary of operation
// RL1 - Test port pins; all other digital pins scanned.
// RL2 - Sixteen-state controller stepped by clock and mode select.
// RL3 - Power-on reset forces Test-Logic-Reset state.
// RL4 - Five-bit instruction picks data register, pin behaviour.
// RL5 - Undefined instruction codes behave as bypass.
// RL6 - EXTEST: chain selected, pins driven from cells.
// RL7 - SAMPLE: chain captures, preloads, pins untouched.
// RL8 - HIGHZ: outputs floated, bypass register selected.
// RL9 - CLAMP: pins from cells, bypass register shifts.
// RL10 - IDCODE selects the 32-bit identification register.
// RL11 - Bypass is one shift stage between ports.
// RL12 - Identification: version, part, maker, fixed one.
// RL13 - Chain of cells from serial in to out.
// RL14 - Supply, ground, test pins not in chain.
// RL15 - Input, output, bidirectional, control cell types.
// RL16 - Cells are test-only, bypassed in normal use.
// RL17 - Cells capture pins on rising test clock; here they capture a synchronised copy two test clocks old.
// RL18 - Inputs on rise; output on fall, floated otherwise.
// RL19 - Test reset forces reset state and IDCODE.
`timescale 1ns/100ps
`default_nettype none
module jtbs_tap #(
  parameter int unsigned N_IN    = 2,
  parameter int unsigned N_OUT   = 2,
  parameter int unsigned N_BIDIR = 2,
  parameter logic [3:0]  ID_VER  = 4'h1,    // Arbitrary value.
  parameter logic [15:0] ID_PART = 16'h1234, // Arbitrary value.
  parameter logic [10:0] ID_MFR  = 11'h055  // Arbitrary value.
) (
  input  wire logic               sys_clk_i,
  input  wire logic               rst_b_i,
  input  wire logic               en_i,
  input  wire logic               tck_i,
  input  wire logic               trst_b_i,
  input  wire logic               tms_i,
  input  wire logic               tdi_i,
  output logic                    tdo_o,
  output logic                    tdo_oe_b_o,
  input  wire logic [N_IN-1:0]    pad_in_i,
  output logic      [N_IN-1:0]    core_in_o,
  input  wire logic [N_OUT-1:0]   core_out_i,
  output logic      [N_OUT-1:0]   pad_out_o,
  output logic      [N_OUT-1:0]   pad_out_oe_b_o,
  input  wire logic [N_BIDIR-1:0] core_bd_out_i,
  input  wire logic [N_BIDIR-1:0] core_bd_oe_b_i,
  input  wire logic [N_BIDIR-1:0] pad_bd_in_i,
  output logic      [N_BIDIR-1:0] core_bd_in_o,
  output logic      [N_BIDIR-1:0] pad_bd_out_o,
  output logic      [N_BIDIR-1:0] pad_bd_oe_b_o
);
  import jtbs_pkg::*;

  localparam int unsigned LEN   = N_IN + N_OUT + N_BIDIR + 1;
  localparam int unsigned O_LSB = N_IN;
  localparam int unsigned B_LSB = N_IN + N_OUT;
  localparam int unsigned C_BIT = LEN - 1;

  if (N_IN < 1 || N_OUT < 1 || N_BIDIR < 1) begin : g_bad_size
    $error("Each pin group needs at least one pin.");
  end

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  function automatic logic is_defined(input logic [4:0] op);
    is_defined = (op == OP_EXTEST) || (op == OP_SAMPLE) || (op == OP_CLAMP)
              || (op == OP_HIGHZ)  || (op == OP_IDCODE);
  endfunction

  // ----------------------------------------------------------------
  // Test clock domain. Power-on reset arrives through rst_b_i, the test
  // reset pin through trst_b_i; either one alone clears the controller.
  // ----------------------------------------------------------------
  wire logic tap_rst_b = trst_b_i & rst_b_i; // [RL3] [RL19]

  jtbs_state_t  state_reg;
  jtbs_state_t  state_next;
  logic [4:0]   ir_sr_reg;
  logic [4:0]   ir_reg;
  logic         byp_reg;
  logic [31:0]  id_sr_reg;
  logic         upd_tgl_reg;
  logic         tdo_reg;
  logic         tdo_oe_b_reg;
  logic         drv_tck_reg;
  logic         hz_tck_reg;

  always_comb begin
    case (state_reg) // [RL2]
      ST_RESET:  state_next = tms_i ? ST_RESET  : ST_IDLE;
      ST_IDLE:   state_next = tms_i ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: state_next = tms_i ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_next = tms_i ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  state_next = tms_i ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: state_next = tms_i ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: state_next = tms_i ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: state_next = tms_i ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: state_next = tms_i ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: state_next = tms_i ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: state_next = tms_i ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  state_next = tms_i ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: state_next = tms_i ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: state_next = tms_i ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: state_next = tms_i ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: state_next = tms_i ? ST_SEL_DR : ST_IDLE;
      default:   state_next = ST_RESET;
    endcase
  end

  wire logic sel_bsr  = (ir_reg == OP_EXTEST) || (ir_reg == OP_SAMPLE); // [RL6] [RL7]
  wire logic sel_id   = (ir_reg == OP_IDCODE); // [RL10]
  wire logic sel_byp  = !sel_bsr && !sel_id; // [RL5] [RL8] [RL9]
  wire logic drv_bsr  = (ir_reg == OP_EXTEST) || (ir_reg == OP_CLAMP); // [RL6] [RL9]
  wire logic hz_mode  = (ir_reg == OP_HIGHZ); // [RL8]
  wire logic cap_dr   = (state_reg == ST_CAP_DR);
  wire logic sh_dr    = (state_reg == ST_SH_DR);
  wire logic sh_ir    = (state_reg == ST_SH_IR);
  wire logic upd_bsr  = (state_reg == ST_UPD_DR) && sel_bsr;
  wire logic [31:0] id_word = {ID_VER, ID_PART, ID_MFR, ID_FIXED}; // [RL12]
  wire logic bsr_tdo;
  wire logic [LEN-1:0] bsr_upd;
  wire logic [LEN-1:0] bsr_par;
  wire logic dr_tdo   = sel_bsr ? bsr_tdo : (sel_id ? id_sr_reg[0] : byp_reg);
  wire logic ser_tdo  = sh_ir ? ir_sr_reg[0] : dr_tdo;

  always_ff @(posedge tck_i or negedge tap_rst_b) begin
    if (!tap_rst_b) begin
      state_reg <= ST_RESET;
      ir_reg    <= OP_IDCODE;
      ir_sr_reg <= IR_CAPTURE;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_RESET) begin
        ir_reg <= OP_IDCODE; // [RL19]
      end else if (state_reg == ST_UPD_IR) begin
        ir_reg <= is_defined(ir_sr_reg) ? ir_sr_reg : OP_BYPASS; // [RL4] [RL5]
      end
      if (state_reg == ST_CAP_IR) begin
        ir_sr_reg <= IR_CAPTURE;
      end else if (sh_ir) begin
        ir_sr_reg <= {tdi_i, ir_sr_reg[4:1]}; // [RL18]
      end
    end
  end

  always_ff @(posedge tck_i or negedge tap_rst_b) begin
    if (!tap_rst_b) begin
      byp_reg     <= BYP_CAPTURE;
      id_sr_reg   <= '0;
      upd_tgl_reg <= 1'b0;
    end else begin
      if (cap_dr) begin
        byp_reg <= BYP_CAPTURE;
      end else if (sh_dr) begin
        byp_reg <= tdi_i; // [RL11]
      end
      if (cap_dr && sel_id) begin
        id_sr_reg <= id_word; // [RL10]
      end else if (sh_dr && sel_id) begin
        id_sr_reg <= {tdi_i, id_sr_reg[31:1]};
      end
      if (upd_bsr) begin
        upd_tgl_reg <= !upd_tgl_reg;
      end
    end
  end

  // Output moves on the falling edge so the tester has half a period of margin.
  // Mode levels are re-timed here too, so no decode glitch reaches the system clock.
  always_ff @(negedge tck_i or negedge tap_rst_b) begin
    if (!tap_rst_b) begin
      tdo_reg      <= 1'b0;
      tdo_oe_b_reg <= OE_B_OFF;
      drv_tck_reg  <= 1'b0;
      hz_tck_reg   <= 1'b0;
    end else begin
      tdo_reg      <= ser_tdo; // [RL18]
      tdo_oe_b_reg <= !(sh_dr || sh_ir); // [RL18]
      drv_tck_reg  <= drv_bsr;
      hz_tck_reg   <= hz_mode;
    end
  end

  assign tdo_o      = tdo_reg;
  assign tdo_oe_b_o = tdo_oe_b_reg;

  // Control cell sits last; the test port pins have no cell at all.
  assign bsr_par = {pad_bd_oe_b_o[0], pad_bd_in_i, pad_out_o, pad_in_i}; // [RL1] [RL14] [RL15]

  jtbs_bsr_chain #(
    .LEN (LEN)
  ) u_chain (
    .tck_i       (tck_i),
    .tap_rst_b_i (tap_rst_b),
    .capture_i   (cap_dr && sel_bsr),
    .shift_i     (sh_dr && sel_bsr),
    .update_i    (upd_bsr),
    .tdi_i       (tdi_i),
    .par_i       (bsr_par),
    .tdo_o       (bsr_tdo),
    .upd_o       (bsr_upd)
  );

  // ----------------------------------------------------------------
  // System clock domain. Mode levels cross on two stages; the update
  // word crosses with a toggle and is stable long before it is seen.
  // ----------------------------------------------------------------
  logic [1:0]         drv_s_reg;
  logic [1:0]         hz_s_reg;
  logic [2:0]         tgl_s_reg;
  logic [LEN-1:0]     upd_word_reg;
  logic [N_IN-1:0]    in_meta_reg;
  logic [N_IN-1:0]    in_sync_reg;
  logic [N_BIDIR-1:0] bd_meta_reg;
  logic [N_BIDIR-1:0] bd_sync_reg;
  logic [N_OUT-1:0]   pad_out_reg;
  logic [N_OUT-1:0]   pad_oe_b_reg;
  logic [N_BIDIR-1:0] bd_out_reg;
  logic [N_BIDIR-1:0] bd_oe_b_reg;
  logic [N_IN-1:0]    core_in_reg;
  logic [N_BIDIR-1:0] core_bd_reg;

  wire logic drv_s  = drv_s_reg[1];
  wire logic hz_s   = hz_s_reg[1];
  wire logic tgl_ev = tgl_s_reg[2] ^ tgl_s_reg[1];
  wire logic [N_OUT-1:0]   out_cells = upd_word_reg[O_LSB +: N_OUT];
  wire logic [N_BIDIR-1:0] bd_cells  = upd_word_reg[B_LSB +: N_BIDIR];
  wire logic               ctl_cell  = upd_word_reg[C_BIT];

  wire logic [N_OUT-1:0]   pad_out_next  = drv_s ? out_cells : core_out_i; // [RL6] [RL16]
  wire logic [N_OUT-1:0]   pad_oe_b_next = {N_OUT{hz_s}}; // [RL8]
  wire logic [N_BIDIR-1:0] bd_out_next   = drv_s ? bd_cells : core_bd_out_i; // [RL9]
  wire logic [N_BIDIR-1:0] bd_oe_b_next  =
    hz_s ? {N_BIDIR{OE_B_OFF}} : (drv_s ? {N_BIDIR{ctl_cell}} : core_bd_oe_b_i); // [RL8]

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      drv_s_reg    <= '0;
      hz_s_reg     <= '0;
      tgl_s_reg    <= '0;
      upd_word_reg <= '0;
      in_meta_reg  <= '0;
      in_sync_reg  <= '0;
      bd_meta_reg  <= '0;
      bd_sync_reg  <= '0;
    end else if (en_i) begin
      drv_s_reg    <= {drv_s_reg[0], drv_tck_reg};
      hz_s_reg     <= {hz_s_reg[0], hz_tck_reg};
      tgl_s_reg    <= {tgl_s_reg[1:0], upd_tgl_reg};
      in_meta_reg  <= pad_in_i;
      in_sync_reg  <= in_meta_reg;
      bd_meta_reg  <= pad_bd_in_i;
      bd_sync_reg  <= bd_meta_reg;
      if (tgl_ev) begin
        upd_word_reg <= bsr_upd;
      end
    end
  end

  // Pads start floated so nothing is driven before the core settles.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      pad_out_reg  <= '0;
      pad_oe_b_reg <= {N_OUT{OE_B_OFF}};
      bd_out_reg   <= '0;
      bd_oe_b_reg  <= {N_BIDIR{OE_B_OFF}};
      core_in_reg  <= '0;
      core_bd_reg  <= '0;
    end else if (en_i) begin
      pad_out_reg  <= pad_out_next;
      pad_oe_b_reg <= pad_oe_b_next;
      bd_out_reg   <= bd_out_next;
      bd_oe_b_reg  <= bd_oe_b_next;
      core_in_reg  <= in_sync_reg; // [RL7]
      core_bd_reg  <= bd_sync_reg;
    end
  end

  assign pad_out_o      = pad_out_reg;
  assign pad_out_oe_b_o = pad_oe_b_reg;
  assign pad_bd_out_o   = bd_out_reg;
  assign pad_bd_oe_b_o  = bd_oe_b_reg;
  assign core_in_o      = core_in_reg;
  assign core_bd_in_o   = core_bd_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_reset_hold: assert property (@(posedge tck_i) disable iff (!tap_rst_b) // [RL2]
    (state_reg == ST_RESET) && tms_i |=> (state_reg == ST_RESET))
    else $error("Controller left reset state with mode select high.");

  chk_five_ones: assert property (@(posedge tck_i) disable iff (!tap_rst_b) // [RL2]
    tms_i [*5] |=> (state_reg == ST_RESET))
    else $error("Five high mode selects did not reach reset state.");

  chk_reset_ir: assert property (@(posedge tck_i) disable iff (!tap_rst_b) // [RL19]
    (state_reg == ST_RESET) |=> (ir_reg == OP_IDCODE))
    else $error("Instruction not IDCODE after reset state.");

  chk_undef_bypass: assert property (@(posedge tck_i) disable iff (!tap_rst_b) // [RL5]
    (state_reg == ST_UPD_IR) && !is_defined(ir_sr_reg) |=> sel_byp && !drv_bsr && !hz_mode)
    else $error("Undefined code did not act as bypass.");

  chk_ir_capture: assert property (@(posedge tck_i) disable iff (!tap_rst_b) // [RL4]
    (state_reg == ST_CAP_IR) |=> (ir_sr_reg == IR_CAPTURE))
    else $error("Instruction capture pattern wrong.");

  chk_id_load: assert property (@(posedge tck_i) disable iff (!tap_rst_b) // [RL10] [RL12]
    cap_dr && sel_id |=> (id_sr_reg == id_word) && id_sr_reg[0])
    else $error("Identification word not captured.");

  chk_bypass_path: assert property (@(posedge tck_i) disable iff (!tap_rst_b) // [RL11]
    sh_dr && sel_byp ##1 sh_dr |-> byp_reg == $past(tdi_i))
    else $error("Bypass stage did not take serial input.");

  chk_tdo_float: assert property (@(negedge tck_i) disable iff (!tap_rst_b) // [RL18]
    !(sh_dr || sh_ir) |=> tdo_oe_b_o)
    else $error("Serial output driven outside shift states.");

  chk_highz_pads: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [RL8]
    hz_s && en_i |=> (&pad_out_oe_b_o) && (&pad_bd_oe_b_o))
    else $error("Pads driven under float instruction.");

  chk_drive_cells: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [RL6]
    drv_s && en_i |=> (pad_out_o == $past(out_cells)))
    else $error("Outputs not driven from cells.");

  chk_tdo_drive: assert property (@(negedge tck_i) disable iff (!tap_rst_b) // [RL18]
    (sh_dr || sh_ir) |=> !tdo_oe_b_o)
    else $error("Serial output floated in a shift state.");

  chk_ir_update: assert property (@(posedge tck_i) disable iff (!tap_rst_b) // [RL4]
    (state_reg == ST_UPD_IR) && is_defined(ir_sr_reg) |=> (ir_reg == $past(ir_sr_reg)))
    else $error("Defined instruction not taken at update.");

endmodule
`default_nettype wire

// >>> dv/jtbs_tester.sv
// Model of the board tester that drives the test port from outside.
// Assumes the bench calls one task at a time and reads oe_bad afterwards.
`timescale 1ns/100ps
`default_nettype none
module jtbs_tester (
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  output logic      trst_b_o,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_b_i
);
  // ----------------------------------------------------------------
  // Frame driving
  // ----------------------------------------------------------------
  logic oe_bad;
  logic shifting;

  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
    trst_b_o = 1'b1;
    oe_bad = 1'b0;
    shifting = 1'b0;
  end

  // The test clock rests low between frames; it only runs inside one.
  task automatic step(input logic m, input logic d, output logic q);
    tms_o = m;
    tdi_o = d;
    #32;
    q = tdo_i;
    if (shifting && tdo_oe_b_i !== 1'b0) begin
      oe_bad = 1'b1;
    end
    tck_o = 1'b1;
    #32;
    tck_o = 1'b0;
  endtask

  task automatic to_idle();
    logic q;
    for (int i = 0; i < 5; i++) begin
      step(1'b1, 1'b0, q);
    end
    step(1'b0, 1'b0, q);
  endtask

  task automatic hard_reset();
    trst_b_o = 1'b0;
    #20;
    trst_b_o = 1'b1;
    #64;
  endtask

  // Two idle clocks first, since captured pin states are two test clocks old.
  task automatic scan(input logic ir, input int len, input logic [63:0] din,
                      output logic [63:0] dout);
    logic q;
    dout = '0;
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b1, 1'b0, q);
    if (ir) begin
      step(1'b1, 1'b0, q);
    end
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    shifting = 1'b1;
    for (int i = 0; i < len; i++) begin
      step(i == len - 1, din[i], q);
      dout[i] = q;
    end
    shifting = 1'b0;
    step(1'b1, ~din[len-1], q);
    step(1'b0, din[len-1], q);
  endtask
endmodule
`default_nettype wire

// >>> dv/jtbs_tap_tb.sv
// Bench for the boundary-scan test port: scenarios, checks and verdict.
// Assumes the tester model drives the test pins and the bench the rest.
`timescale 1ns/100ps
`default_nettype none
module jtbs_tap_tb;
  import jtbs_pkg::*;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  localparam logic [3:0]  VER  = 4'h3;     // Arbitrary value.
  localparam logic [15:0] PART = 16'h0a5c; // Arbitrary value.
  localparam logic [10:0] MFR  = 11'h2b1;  // Arbitrary value.
  logic        sys_clk_i;
  logic        rst_b_i;
  logic        en_i;
  logic        tck, tms, tdi, trst_b, tdo, tdo_oe_b;
  logic [1:0]  pad_in, core_in, core_out, pad_out, out_oe_b;
  logic [1:0]  bd_out, bd_oe_b, bd_ext, bd_pin, bd_in, pbd_out, pbd_oe_b;
  logic [63:0] got;
  int          fails;
  int          checked;

  // A driven bidirectional pin shows the device's value, else the board's.
  assign bd_pin = (~pbd_oe_b & pbd_out) | (pbd_oe_b & bd_ext);

  jtbs_tap #(.ID_VER(VER), .ID_PART(PART), .ID_MFR(MFR)) dut (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .en_i(en_i), .tck_i(tck),
    .trst_b_i(trst_b), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_b_o(tdo_oe_b),
    .pad_in_i(pad_in), .core_in_o(core_in), .core_out_i(core_out),
    .pad_out_o(pad_out), .pad_out_oe_b_o(out_oe_b), .core_bd_out_i(bd_out),
    .core_bd_oe_b_i(bd_oe_b), .pad_bd_in_i(bd_pin), .core_bd_in_o(bd_in),
    .pad_bd_out_o(pbd_out), .pad_bd_oe_b_o(pbd_oe_b));

  jtbs_tester tester (
    .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_b_o(trst_b),
    .tdo_i(tdo), .tdo_oe_b_i(tdo_oe_b));

  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    if (fails == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wait_sys();
    repeat (10) @(negedge sys_clk_i);
  endtask

  task automatic set_pins(input logic [1:0] pi, input logic [1:0] co, input logic [1:0] bo);
    @(negedge sys_clk_i);
    pad_in = pi;
    core_out = co;
    bd_out = bo;
    bd_ext = ~bo;
  endtask

  task automatic set_ir(input logic [4:0] code);
    tester.scan(1'b1, 5, {59'h0, code}, got);
    check("ir_capture", got[4:0], IR_CAPTURE);
  endtask

  task automatic dr(input int len, input logic [63:0] din);
    tester.scan(1'b0, len, din, got);
  endtask

  task automatic chk_normal();
    wait_sys();
    check("pad_out", pad_out, core_out);
    check("pad_out_oe_b", out_oe_b, 2'b00);
    check("core_in", core_in, pad_in);
    check("core_bd_in", bd_in, bd_pin);
    check("pad_bd", {pbd_oe_b, pbd_out}, {bd_oe_b, bd_out});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_id();
    dr(32, 64'h0);
    check("idcode", got[31:0], {VER, PART, MFR, ID_FIXED});
    check("tdo_oe_shift", tester.oe_bad, 1'b0);
    check("tdo_oe_idle", tdo_oe_b, 1'b1);
    chk_normal();
    @(negedge sys_clk_i);
    en_i = 1'b0;
    core_out = 2'b10;
    bd_oe_b = 2'b10;
    wait_sys();
    check("frozen_pads", {out_oe_b, pad_out, pbd_oe_b}, 6'h00);
    en_i = 1'b1;
    chk_normal();
    @(negedge sys_clk_i);
    core_out = 2'b00;
    bd_oe_b = 2'b00;
  endtask

  task automatic t_bypass();
    logic [4:0] codes [5] = '{OP_BYPASS, 5'h02, 5'h09, 5'h0a, 5'h1e};
    foreach (codes[i]) begin
      set_ir(codes[i]);
      dr(8, 64'h5a);
      check("bypass_path", got[7:0], {7'h5a, BYP_CAPTURE});
    end
    tester.to_idle();
    dr(32, 64'h0);
    check("id_after_tms", got[31:0], {VER, PART, MFR, ID_FIXED});
  endtask

  task automatic t_modes();
    set_pins(2'b10, 2'b01, 2'b11);
    set_ir(OP_SAMPLE);
    chk_normal();
    dr(7, 64'h1b);
    check("sample_capture", got[6:0], 7'b0110110);
    chk_normal();
    set_pins(2'b01, 2'b01, 2'b11);
    set_ir(OP_EXTEST);
    wait_sys();
    check("extest_out", {out_oe_b, pad_out}, 4'b0010);
    check("extest_bd", {pbd_oe_b, pbd_out}, 4'b0001);
    dr(7, 64'h1b);
    check("extest_capture", got[6:0], 7'b0011001);
    set_ir(OP_CLAMP);
    wait_sys();
    check("clamp_pins", {out_oe_b, pad_out, pbd_oe_b, pbd_out}, 8'h21);
    dr(8, 64'h5a);
    check("clamp_path", got[7:0], 8'hb4);
    set_ir(OP_HIGHZ);
    wait_sys();
    check("highz_oe", {out_oe_b, pbd_oe_b}, 4'hf);
    dr(8, 64'h5a);
    check("highz_path", got[7:0], 8'hb4);
    tester.hard_reset();
    check("trst_tdo_oe", tdo_oe_b, 1'b1);
    chk_normal();
    dr(32, 64'h0);
    check("id_after_trst", got[31:0], {VER, PART, MFR, ID_FIXED});
    check("tdo_oe_all_shifts", tester.oe_bad, 1'b0);
  endtask

  // About twenty frames of some twenty test clocks each, with margin.
  initial begin
    #500us;
    fails++;
    stop_test();
  end

  initial begin
    fails = 0;
    checked = 0;
    rst_b_i = 1'b0;
    en_i = 1'b1;
    pad_in = 2'b00;
    core_out = 2'b00;
    bd_out = 2'b00;
    bd_oe_b = 2'b00;
    bd_ext = 2'b00;
    repeat (2) @(negedge sys_clk_i);
    rst_b_i = 1'b1;
    #100;
    t_reset_id();
    t_bypass();
    t_modes();
    stop_test();
  end
endmodule
`default_nettype wire
